// >>> cri_core.sv
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Reset pin must stay low at least 10 system states to be accepted.
// [R2] On reset, program counter loads vector from bytes FFFF00H to FFFF02H.
// [R3] On reset, the extended stack pointer becomes 100H.
// [R4] On reset, interrupt mask level becomes 111, masking up to level 7.
// [R5] Reset sets maximum-mode bit; software must never clear it.
// [R6] On reset, register bank pointer clears to 000.
// [R7] After release, fetching starts at the program counter address.
// [R8] Reset leaves all other CPU registers unchanged.
// [R9] While reset is accepted, internal I/O registers take initial values.
// [R10] While reset is accepted, the clock output pin is driven high.
// [R11] Addresses 000000H to 00003FH decode as the 64-byte internal I/O area.
// [R12] Short direct addressing reaches the internal I/O area.
// [R13] Outside reset, the clock output is the oscillator clock divided by 4.
// [R14] Vector bytes assemble low address as least significant byte.
module cri_core
  import cri_pkg::*;
#(
  parameter int unsigned MIN_STATES = cri_pkg::RESET_MIN_STATES
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Reset pin.
  input  wire logic        reset_pin_n,
  // Vector fetch from external memory.
  output logic [23:0]      vec_addr,
  output logic             vec_req,
  input  wire logic [7:0]  vec_data,
  input  wire logic        vec_valid,
  // Fetch and decode view.
  output logic [23:0]      fetch_addr,
  output logic             fetch_start,
  input  wire logic [23:0] cpu_addr,
  input  wire logic        short_direct,
  input  wire logic [7:0]  short_addr,
  output logic             io_select,
  output logic [23:0]      eff_addr,
  // Pin.
  output logic             clk_out,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o
);
  import cri_pkg::*;

  logic          accepted;
  cri_state_type state_reg, state_next;
  logic [23:0]   pc_reg, pc_next;
  logic [31:0]   sp_reg, sp_next;
  logic [15:0]   sr_reg, sr_next;
  logic [7:0]    io_reg, io_next;
  logic [1:0]    div_reg, div_next;
  logic          clk_reg, clk_next;
  logic          start_reg, start_next;
  logic          ack_reg, ack_next;
  logic          err_reg, err_next;
  logic [31:0]   rd_reg, rd_next;
  logic          wb_req, wr_ok;

  cri_reset_filter #(
    .MIN_STATES (MIN_STATES),
    .STATE_DIV  (STATE_DIV)
  ) u_filter (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .reset_pin_n (reset_pin_n),
    .accepted    (accepted)
  );

  function automatic logic in_io(input logic [23:0] a);
    in_io = (a >= IO_BASE) && (a <= IO_LAST); // see [R11]
  endfunction : in_io

  assign eff_addr  = short_direct ? {16'h0000, short_addr}
                                  : cpu_addr; // see [R12]
  assign io_select = in_io(eff_addr); // see [R11] [R12]

  assign vec_req     = (state_reg == CRI_VEC0) || (state_reg == CRI_VEC1) ||
                       (state_reg == CRI_VEC2);
  assign vec_addr    = RESET_VECTOR_ADDR +
                       24'(state_reg == CRI_VEC1) +
                       24'((state_reg == CRI_VEC2) ? 2 : 0); // see [R2]
  assign fetch_addr  = pc_reg;
  assign fetch_start = start_reg;
  assign clk_out     = clk_reg;
  assign wb_ack_o    = ack_reg;
  assign wb_err_o    = err_reg;
  assign wb_dat_o    = rd_reg;
  assign wb_req      = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;

  // Reset and vector fetch sequencer.
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    sp_next    = sp_reg;
    sr_next    = sr_reg;
    io_next    = io_reg;
    start_next = 1'b0;
    if (accepted) begin
      state_next = CRI_HELD;
      sp_next    = STACK_RESET; // see [R3]
      sr_next[SR_IMASK_LSB +: 3] = IMASK_RESET; // see [R4]
      sr_next[SR_MAX_BIT]        = MAXMODE_RESET; // see [R5]
      sr_next[SR_BANK_LSB +: 3]  = BANK_RESET; // see [R6]
      io_next    = IOREG_RESET; // see [R9]
      // Other status bits are kept as they were.
    end else begin
      case (state_reg)
        CRI_HELD: begin
          state_next = CRI_VEC0;
        end
        CRI_VEC0: begin
          if (vec_valid) begin
            pc_next[7:0] = vec_data; // see [R14]
            state_next   = CRI_VEC1;
          end
        end
        CRI_VEC1: begin
          if (vec_valid) begin
            pc_next[15:8] = vec_data; // see [R14]
            state_next    = CRI_VEC2;
          end
        end
        CRI_VEC2: begin
          if (vec_valid) begin
            pc_next[23:16] = vec_data; // see [R2] [R14]
            state_next     = CRI_RUN;
            start_next     = 1'b1; // see [R7]
          end
        end
        default: begin
          state_next = CRI_RUN;
        end
      endcase
      if (wr_ok && wb_adr_i == ADDR_IOREG && wb_sel_i[0]) begin
        io_next = wb_dat_i[7:0];
      end
      if (wr_ok && wb_adr_i == ADDR_SR) begin
        if (wb_sel_i[0]) sr_next[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) begin
          sr_next[15:8] = wb_dat_i[15:8];
          // Minimum mode is not supported, so the mode bit stays set.
          sr_next[SR_MAX_BIT] = 1'b1; // see [R5]
        end
      end
    end
  end

  // Clock output: divide by four, forced high during reset.
  always_comb begin
    div_next = div_reg + 2'h1;
    clk_next = clk_reg;
    if (accepted) begin
      div_next = 2'h0;
      clk_next = 1'b1; // see [R10]
    end else if (div_reg == 2'(CLKOUT_DIV / 2 - 1)) begin
      div_next = 2'h0;
      clk_next = !clk_reg; // see [R13]
    end
  end

  // A write lands at the edge at which the master samples ack high.
  assign wr_ok = ack_reg && wb_cyc_i && wb_stb_i && wb_we_i;

  // Wishbone register access, one wait state.
  always_comb begin
    ack_next  = 1'b0;
    err_next  = 1'b0;
    rd_next   = rd_reg;
    if (wb_req) begin
      if (wb_adr_i == ADDR_CTRL) begin
        rd_next  = {31'h0, accepted};
        ack_next = 1'b1;
      end else if (wb_adr_i == ADDR_STATUS) begin
        rd_next  = {25'h0, start_reg, state_reg == CRI_RUN, 3'(state_reg),
                    clk_reg, accepted};
        ack_next = 1'b1;
      end else if (wb_adr_i == ADDR_PC) begin
        rd_next  = {8'h00, pc_reg};
        ack_next = 1'b1;
      end else if (wb_adr_i == ADDR_SP) begin
        rd_next  = sp_reg;
        ack_next = 1'b1;
      end else if (wb_adr_i == ADDR_SR) begin
        rd_next  = {16'h0000, sr_reg};
        ack_next = 1'b1;
      end else if (wb_adr_i == ADDR_IOREG) begin
        rd_next  = {24'h0, io_reg};
        ack_next = 1'b1;
      end else if (wb_adr_i == ADDR_DECODE) begin
        rd_next  = {31'h0, io_select};
        ack_next = 1'b1;
      end else begin
        rd_next  = 32'h0;
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= CRI_HELD;
      pc_reg    <= 24'h000000;
      sp_reg    <= STACK_RESET;
      // Power-on reset presets the status fields as a pin reset does.
      sr_reg    <= {MAXMODE_RESET, IMASK_RESET, 1'b0, BANK_RESET, 8'h00};
      io_reg    <= IOREG_RESET;
      div_reg   <= 2'h0;
      clk_reg   <= 1'b1;
      start_reg <= 1'b0;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rd_reg    <= 32'h0;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      sp_reg    <= sp_next;
      sr_reg    <= sr_next;
      io_reg    <= io_next;
      div_reg   <= div_next;
      clk_reg   <= clk_next;
      start_reg <= start_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      rd_reg    <= rd_next;
    end
  end

  sequence s_accept;
    accepted;
  endsequence
  sequence s_released;
    !accepted ##1 !accepted;
  endsequence

  a_sp_preset: assert property (@(posedge mclk) disable iff (!rst_n)
    s_accept |=> sp_reg == STACK_RESET) // see [R3]
    else $error("stack pointer not preset");
  a_imask_preset: assert property (@(posedge mclk) disable iff (!rst_n)
    s_accept |=> sr_reg[SR_IMASK_LSB +: 3] == IMASK_RESET) // see [R4]
    else $error("mask level not preset");
  a_max_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(accepted) |-> sr_reg[SR_MAX_BIT]) // see [R5]
    else $error("mode bit clear after reset");
  a_bank_preset: assert property (@(posedge mclk) disable iff (!rst_n)
    s_accept |=> sr_reg[SR_BANK_LSB +: 3] == BANK_RESET) // see [R6]
    else $error("bank pointer not cleared");
  a_io_init: assert property (@(posedge mclk) disable iff (!rst_n)
    s_accept |=> io_reg == IOREG_RESET) // see [R9]
    else $error("io register not initialised");
  a_clk_high: assert property (@(posedge mclk) disable iff (!rst_n)
    s_accept ##1 accepted |-> clk_out) // see [R10]
    else $error("clock pin low during reset");
  a_clk_div: assert property (@(posedge mclk) disable iff (!rst_n)
    s_released ##0 $changed(clk_out) |-> ##2 ($changed(clk_out) || accepted))
    // see [R13]
    else $error("clock output not divided by four");
  a_pc_vector: assert property (@(posedge mclk) disable iff (!rst_n)
    start_reg |-> fetch_addr == pc_reg && state_reg == CRI_RUN) // see [R7]
    else $error("fetch start without vector loaded");
  a_vec_order: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_reg == CRI_VEC2) |-> vec_addr == RESET_VECTOR_ADDR + 24'h000002)
    // see [R2] [R14]
    else $error("vector high byte address wrong");
  a_io_window: assert property (@(posedge mclk) disable iff (!rst_n)
    io_select == (eff_addr <= IO_LAST)) // see [R11]
    else $error("io window decode wrong");
  a_sr_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    accepted && $past(accepted) |-> sr_reg[7:0] == $past(sr_reg[7:0]))
    // see [R8]
    else $error("reset altered unlisted status bits");

  // The last vector byte completes the counter and starts the fetch.
  sequence s_vec_last;
    state_reg == CRI_VEC2 && vec_valid && !accepted;
  endsequence

  a_vec_first: assert property (@(posedge mclk) // see [R2]
    disable iff (!rst_n) state_reg == CRI_VEC0 |->
    vec_addr == RESET_VECTOR_ADDR)
    else $error("vector low byte address wrong");
  a_pc_low_byte: assert property (@(posedge mclk) // see [R14]
    disable iff (!rst_n) state_reg == CRI_VEC0 && vec_valid && !accepted
    |=> pc_reg[7:0] == $past(vec_data))
    else $error("vector low byte not in low end of counter");
  a_pc_high_byte: assert property (@(posedge mclk) // see [R2] [R14]
    disable iff (!rst_n) s_vec_last
    |=> pc_reg[23:16] == $past(vec_data))
    else $error("vector high byte not in high end of counter");
  a_fetch_after: assert property (@(posedge mclk) // see [R7]
    disable iff (!rst_n) s_vec_last |=> start_reg ##1 !start_reg)
    else $error("fetch start not a single pulse after the vector");
  a_max_always: assert property (@(posedge mclk) // see [R5]
    disable iff (!rst_n) sr_reg[SR_MAX_BIT])
    else $error("mode bit found clear");
  a_short_direct: assert property (@(posedge mclk) // see [R12]
    disable iff (!rst_n) short_direct |->
    eff_addr == {16'h0000, short_addr})
    else $error("short address not mapped to the low page");
  a_ack_pulse: assert property (@(posedge mclk)
    disable iff (!rst_n) wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  a_bus_quiet: assert property (@(posedge mclk)
    disable iff (!rst_n) !wb_cyc_i |=> !wb_ack_o && !wb_err_o)
    else $error("bus answer without a request");
endmodule : cri_core
`default_nettype wire

// >>> cri_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cri_partner #(
  parameter logic [23:0] VECTOR = 24'h123456
) (
  // Clock.
  input  wire logic        mclk,
  // Reset circuit control.
  input  wire logic        go,
  input  wire logic [7:0]  low_len,
  output logic             reset_pin_n,
  // Vector memory.
  input  wire logic [23:0] vec_addr,
  input  wire logic        vec_req,
  input  wire logic [3:0]  dly,
  output logic [7:0]       vec_data,
  output logic             vec_valid
);
  logic [7:0] low_cnt;
  logic [3:0] wait_cnt;
  initial begin
    low_cnt = 8'h00;
    wait_cnt = 4'h0;
    vec_valid = 1'b0;
    vec_data = 8'h00;
  end
  // The pin idles at its pull-up level between pulses.
  assign reset_pin_n = (low_cnt == 8'h00);
  always @(posedge mclk) begin
    low_cnt <= go ? low_len : (low_cnt != 8'h00 ? low_cnt - 8'h01 : 8'h00);
    vec_valid <= 1'b0;
    vec_data <= ~vec_data;
    if (vec_req && !vec_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= dly) begin
        wait_cnt <= 4'h0;
        vec_valid <= 1'b1;
        vec_data <= VECTOR[8*vec_addr[1:0] +: 8];
      end
    end
  end
endmodule : cri_partner
`default_nettype wire

// >>> cri_pkg.sv
package cri_pkg;
  localparam int unsigned RESET_MIN_STATES  = 10;
  localparam logic [23:0] RESET_VECTOR_ADDR = 24'hFFFF00;
  localparam logic [31:0] STACK_RESET       = 32'h00000100;
  localparam logic [2:0]  IMASK_RESET       = 3'h7;
  localparam logic        MAXMODE_RESET     = 1'h1;
  localparam logic [2:0]  BANK_RESET        = 3'h0;
  localparam logic [23:0] IO_BASE           = 24'h000000;
  localparam logic [23:0] IO_LAST           = 24'h00003F;
  localparam int unsigned CLKOUT_DIV        = 4;
  localparam int unsigned STATE_DIV         = 2;
  localparam int unsigned SR_IMASK_LSB      = 12;
  localparam int unsigned SR_MAX_BIT        = 15;
  localparam int unsigned SR_BANK_LSB       = 8;
  localparam logic [7:0]  ADDR_CTRL         = 8'h00;
  localparam logic [7:0]  ADDR_STATUS       = 8'h04;
  localparam logic [7:0]  ADDR_PC           = 8'h08;
  localparam logic [7:0]  ADDR_SP           = 8'h0C;
  localparam logic [7:0]  ADDR_SR           = 8'h10;
  localparam logic [7:0]  ADDR_IOREG        = 8'h14;
  localparam logic [7:0]  ADDR_DECODE       = 8'h18;
  localparam logic [7:0]  IOREG_RESET       = 8'h00;
  typedef enum logic [2:0] {
    CRI_HELD  = 3'h0,
    CRI_VEC0  = 3'h1,
    CRI_VEC1  = 3'h2,
    CRI_VEC2  = 3'h3,
    CRI_RUN   = 3'h4
  } cri_state_type;
endpackage : cri_pkg

// >>> cri_reset_filter.sv
`timescale 1ns/1ps
`default_nettype none
module cri_reset_filter #(
  parameter int unsigned MIN_STATES = 10,
  parameter int unsigned STATE_DIV  = 2
) (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst_n,
  // Pin side.
  input  wire logic reset_pin_n,
  // Result.
  output logic      accepted
);
  logic       sync1_reg, sync2_reg, sync1_next, sync2_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] cnt_reg, cnt_next;
  logic       acc_reg, acc_next;
  logic       state_en;

  assign state_en = (div_reg == 8'(STATE_DIV - 1));
  assign accepted = acc_reg;

  always_comb begin
    sync1_next = reset_pin_n;
    sync2_next = sync1_reg;
    div_next   = state_en ? 8'h00 : div_reg + 8'h01;
    cnt_next   = cnt_reg;
    acc_next   = acc_reg;
    if (sync2_reg) begin
      cnt_next = 8'h00;
      acc_next = 1'b0;
    end else if (state_en && cnt_reg < 8'(MIN_STATES)) begin
      cnt_next = cnt_reg + 8'h01;
    end
    // The pin must stay low a full run of states before reset takes hold.
    if (!sync2_reg && cnt_reg >= 8'(MIN_STATES)) begin // see [R1]
      acc_next = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      div_reg   <= 8'h00;
      cnt_reg   <= 8'h00;
      acc_reg   <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      div_reg   <= div_next;
      cnt_reg   <= cnt_next;
      acc_reg   <= acc_next;
    end
  end

  a_accept_after_low: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(acc_reg) |-> $past(cnt_reg) >= 8'(MIN_STATES)) // see [R1]
    else $error("reset accepted before the minimum low time");
endmodule : cri_reset_filter
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cri_pkg::*;
  logic mclk, rst_n, go, short_direct, cyc, stb, we, ack, err, werr;
  logic vec_valid, vec_req, fetch_start, io_select, clk_out, reset_pin_n;
  logic [7:0]  low_len, short_addr, adr, vec_data, cv;
  logic [3:0]  dly, sel;
  logic [23:0] cpu_addr, vec_addr, fetch_addr, eff_addr, ee;
  logic [31:0] wdat, dat_o, q;
  int err_count, compares;
  cri_core #(.MIN_STATES(3)) cri_core_inst (.mclk(mclk), .rst_n(rst_n),
    .reset_pin_n(reset_pin_n), .vec_addr(vec_addr), .vec_req(vec_req),
    .vec_data(vec_data), .vec_valid(vec_valid), .fetch_addr(fetch_addr),
    .fetch_start(fetch_start), .cpu_addr(cpu_addr),
    .short_direct(short_direct), .short_addr(short_addr),
    .io_select(io_select), .eff_addr(eff_addr), .clk_out(clk_out),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err));
  cri_partner cri_partner_inst (.mclk(mclk), .go(go), .low_len(low_len),
    .reset_pin_n(reset_pin_n), .vec_addr(vec_addr), .vec_req(vec_req),
    .dly(dly), .vec_data(vec_data), .vec_valid(vec_valid));
  task automatic chk(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = dat_o;
    werr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wb
  task automatic wait_fetch;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (fetch_start !== 1'b1 && n < 200);
    chk("fetch_start", 32'(fetch_start), 32'h1);
    chk("fetch_addr", 32'(fetch_addr), 32'h00123456);
  endtask : wait_fetch
  task automatic pin_pulse(input logic [7:0] len);
    low_len <= len;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask : pin_pulse
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    stop_test();
  end
  initial begin
    err_count = 0;
    compares = 0;
    {rst_n, go, short_direct, cyc, stb, we} = 6'h00;
    {low_len, short_addr, adr, dly, sel} = 32'h0;
    cpu_addr = 24'h000000;
    wdat = 32'h0;
    repeat (20) @(posedge mclk);
    chk("clk_out in reset", 32'(clk_out), 32'h1);
    rst_n <= 1'b1;
    wait_fetch();
    wb(1'b0, ADDR_SP, 32'h0, 4'hF);
    chk("sp", q, STACK_RESET);
    wb(1'b0, ADDR_SR, 32'h0, 4'hF);
    chk("sr", q & 32'hFF00, {16'h0, MAXMODE_RESET, IMASK_RESET, 1'b0,
        BANK_RESET, 8'h00});
    wb(1'b0, ADDR_IOREG, 32'h0, 4'hF);
    chk("ioreg", q, 32'(IOREG_RESET));
    wb(1'b0, ADDR_PC, 32'h0, 4'hF);
    chk("pc", q, 32'h00123456);
    wb(1'b0, ADDR_DECODE, 32'h0, 4'hF);
    chk("decode", q, 32'h1);
    $display("test power-on reset done");
    // Software keeps the mode bit set whenever it writes the status.
    wb(1'b1, ADDR_SR, 32'h000088A5, 4'h3);
    wb(1'b0, ADDR_SR, 32'h0, 4'hF);
    chk("sr max kept", q, 32'h000088A5);
    wb(1'b1, ADDR_SP, 32'h00001234, 4'hF);
    wb(1'b0, ADDR_SP, 32'h0, 4'hF);
    chk("sp read only", q, STACK_RESET);
    wb(1'b1, ADDR_IOREG, 32'h0000005A, 4'h1);
    wb(1'b0, 8'hFC, 32'h0, 4'hF);
    chk("unmapped err", 32'(werr), 32'h1);
    chk("unmapped data", q, 32'h0);
    // Two states low is one short of the minimum and must be ignored.
    pin_pulse(8'd4);
    repeat (30) @(posedge mclk);
    wb(1'b0, ADDR_IOREG, 32'h0, 4'hF);
    chk("ioreg short pulse", q, 32'h0000005A);
    $display("test short pulse done");
    dly <= 4'h4;
    pin_pulse(8'd20);
    repeat (16) @(posedge mclk);
    chk("clk_out pin reset", 32'(clk_out), 32'h1);
    wb(1'b0, ADDR_CTRL, 32'h0, 4'hF);
    chk("ctrl accepted", q, 32'h1);
    wait_fetch();
    wb(1'b0, ADDR_SP, 32'h0, 4'hF);
    chk("sp pin reset", q, STACK_RESET);
    wb(1'b0, ADDR_SR, 32'h0, 4'hF);
    chk("sr pin reset", q, 32'h0000F8A5);
    wb(1'b0, ADDR_IOREG, 32'h0, 4'hF);
    chk("ioreg pin reset", q, 32'(IOREG_RESET));
    $display("test pin reset done");
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      cv[k] = clk_out;
    end
    for (int k = 0; k < 6; k++)
      chk("clk_out div", 32'(cv[k+2]), 32'(!cv[k]));
    $display("test clock divider done");
    for (int i = 0; i < 4; i++) begin
      short_direct <= i[1];
      short_addr <= i[0] ? 8'h40 : 8'h3F;
      cpu_addr <= i[0] ? 24'h00003F : 24'h000040;
      ee = i[1] ? {16'h0, (i[0] ? 8'h40 : 8'h3F)} :
           (i[0] ? 24'h00003F : 24'h000040);
      @(posedge mclk);
      @(posedge mclk);
      chk("eff_addr", 32'(eff_addr), 32'(ee));
      chk("io_select", 32'(io_select), 32'(ee <= IO_LAST));
    end
    $display("test decode done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
